/* logic/nvss_seq.sv */
// Contract
// - Skip store when no write since cycle; the code still runs soft STORE commands with no write
// - Access stays enabled briefly after trigger; the code sets access_inhibit during S_GRACE
// - Ignore accesses during store or recall
// - Access off while store line held low
// - No drive on store line when skipped
// - Act on soft commands within processing time
// - Lock out I/O until store/recall ends
// - Become active soon after line released
// - Drive line high briefly after store
`timescale 1ns/1ps
`include "nvss_map.svh"
module nvss_seq #(
  parameter int STORE_CYC = `NVSS_STORE_CYC,
  parameter int RECALL_CYC = `NVSS_RECALL_CYC,
  parameter int SS_CYC = `NVSS_SS_CYC,
  parameter int ACTIVE_CYC = `NVSS_ACTIVE_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire nvss_pkg::nvss_cmd_t cmd,
  input wire logic cmd_valid,
  input wire logic sram_write,
  input wire logic power_fail,
  input wire logic hw_store_busy_line_in,
  output logic hw_store_busy_line_out,
  output logic hw_store_busy_line_oe,
  output logic access_inhibit,
  output logic busy,
  output logic nv_store_go,
  output logic nv_recall_go,
  output logic power_fail_store_en
);
  import nvss_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_PEND, S_GRACE, S_STORE, S_RECALL, S_DRIVE, S_WAKE
  } nvss_state_t;

  localparam int TW = 19;
  localparam logic [TW-1:0] DELAY_C = TW'(`NVSS_DELAY_CYC);
  localparam logic [TW-1:0] DRIVE_C = TW'(`NVSS_DRIVE_CYC);

  nvss_state_t state_q;
  nvss_cmd_t pend_q;
  logic write_flag_q;
  logic is_store_q;
  logic hw_req_q;
  logic load_d;
  logic [TW-1:0] value_d;
  logic tdone;

  function automatic logic is_nv(input nvss_cmd_t c);
    return c == NVSS_CMD_STORE || c == NVSS_CMD_RECALL;
  endfunction : is_nv

  ////////////////////////////////////////////////////////////////
  // Timer
  nvss_timer #(.W(TW)) u_timer (
    .mclk(mclk),
    .rst_b(rst_b),
    .load(load_d),
    .value(value_d),
    .done(tdone)
  );

  wire logic hw_fall = !hw_store_busy_line_in && !hw_req_q;
  wire logic pf_go = power_fail && power_fail_store_en && write_flag_q;

  always_comb begin
    load_d = 1'b0;
    value_d = '0;
    case (state_q)
      S_IDLE: begin
        if (cmd_valid && cmd != NVSS_CMD_NONE) begin
          load_d = 1'b1;
          value_d = TW'(SS_CYC - 3);
        end else if ((hw_fall || pf_go) && write_flag_q) begin
          load_d = 1'b1;
          value_d = DELAY_C;
        end
      end
      S_PEND: begin
        if (tdone && is_nv(pend_q)) begin
          load_d = 1'b1;
          value_d = DELAY_C;
        end
      end
      S_GRACE: begin
        if (tdone) begin
          load_d = 1'b1;
          value_d = is_store_q ? TW'(STORE_CYC) : TW'(RECALL_CYC);
        end
      end
      S_STORE: begin
        if (tdone) begin
          load_d = 1'b1;
          value_d = DRIVE_C - TW'(1);
        end
      end
      S_RECALL, S_DRIVE: begin
        if (tdone) begin
          load_d = 1'b1;
          value_d = TW'(ACTIVE_CYC);
        end
      end
      default: begin
        load_d = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      pend_q <= NVSS_CMD_NONE;
      is_store_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (cmd_valid && cmd != NVSS_CMD_NONE) begin
            pend_q <= cmd;
            state_q <= S_PEND;
          end else if ((hw_fall || pf_go) && write_flag_q) begin
            is_store_q <= 1'b1;
            state_q <= S_GRACE;
          end
        end
        S_PEND: begin
          if (tdone) begin
            is_store_q <= pend_q == NVSS_CMD_STORE;
            state_q <= is_nv(pend_q) ? S_GRACE : S_IDLE;
          end
        end
        S_GRACE: begin
          if (tdone) begin
            state_q <= is_store_q ? S_STORE : S_RECALL;
          end
        end
        S_STORE: begin
          if (tdone) begin
            state_q <= S_DRIVE;
          end
        end
        S_RECALL, S_DRIVE: begin
          if (tdone) begin
            state_q <= S_WAKE;
          end
        end
        S_WAKE: begin
          if (tdone) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Hardware request edge and write flag
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hw_req_q <= 1'b0;
    end else begin
      hw_req_q <= !hw_store_busy_line_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      write_flag_q <= 1'b0;
    end else if (sram_write && !access_inhibit) begin
      write_flag_q <= 1'b1;
    end else if ((state_q == S_STORE || state_q == S_RECALL) && tdone) begin
      write_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      power_fail_store_en <= 1'b1;
    end else if (state_q == S_PEND && tdone && pend_q == NVSS_CMD_PFS_EN) begin
      power_fail_store_en <= 1'b1;
    end else if (state_q == S_PEND && tdone && pend_q == NVSS_CMD_PFS_DIS) begin
      power_fail_store_en <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      access_inhibit <= 1'b0;
      busy <= 1'b0;
      nv_store_go <= 1'b0;
      nv_recall_go <= 1'b0;
      hw_store_busy_line_out <= 1'b1;
      hw_store_busy_line_oe <= 1'b0;
    end else begin
      access_inhibit <= (state_q == S_STORE) || (state_q == S_RECALL)
        || (state_q == S_DRIVE) || (state_q == S_WAKE)
        || (state_q == S_GRACE)
        || !hw_store_busy_line_in;
      busy <= state_q != S_IDLE;
      nv_store_go <= state_q == S_GRACE && tdone && is_store_q;
      nv_recall_go <= state_q == S_GRACE && tdone && !is_store_q;
      hw_store_busy_line_out <= !(state_q == S_STORE || (state_q == S_GRACE && tdone && is_store_q));
      hw_store_busy_line_oe <= state_q == S_STORE || state_q == S_DRIVE
        || (state_q == S_GRACE && tdone && is_store_q);
    end
  end
endmodule : nvss_seq

/* pkg/nvss_map.svh */
`ifndef NVSS_MAP_SVH
`define NVSS_MAP_SVH
`define NVSS_CLK_MHZ 40
`define NVSS_DELAY_NS 25
`define NVSS_SS_US 100
`define NVSS_STORE_MS 8
`define NVSS_RECALL_US 200
`define NVSS_ACTIVE_US 5
`define NVSS_DRIVE_NS 500
`define NVSS_DELAY_CYC (((`NVSS_DELAY_NS * `NVSS_CLK_MHZ) / 1000) < 1 ? 1 : ((`NVSS_DELAY_NS * `NVSS_CLK_MHZ) / 1000))
`define NVSS_SS_CYC (`NVSS_SS_US * `NVSS_CLK_MHZ)
`define NVSS_STORE_CYC (`NVSS_STORE_MS * 1000 * `NVSS_CLK_MHZ)
`define NVSS_RECALL_CYC (`NVSS_RECALL_US * `NVSS_CLK_MHZ)
`define NVSS_ACTIVE_CYC (`NVSS_ACTIVE_US * `NVSS_CLK_MHZ)
`define NVSS_DRIVE_CYC ((`NVSS_DRIVE_NS * `NVSS_CLK_MHZ) / 1000)
`endif

/* pkg/nvss_pkg.sv */
package nvss_pkg;
  typedef enum logic [2:0] {
    NVSS_CMD_NONE,
    NVSS_CMD_STORE,
    NVSS_CMD_RECALL,
    NVSS_CMD_PFS_EN,
    NVSS_CMD_PFS_DIS
  } nvss_cmd_t;
endpackage : nvss_pkg

/* logic/nvss_timer.sv */
`timescale 1ns/1ps
module nvss_timer #(
  parameter int W = 19
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic load,
  input wire logic [W-1:0] value,
  output logic done
);
  logic [W-1:0] cnt_q;
  logic run_q;

  // Down counter, one-cycle done pulse at expiry
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      cnt_q <= value;
      run_q <= 1'b1;
      done <= 1'b0;
    end else if (run_q && cnt_q <= W'(1)) begin
      run_q <= 1'b0;
      done <= 1'b1;
    end else begin
      cnt_q <= run_q ? cnt_q - W'(1) : cnt_q;
      done <= 1'b0;
    end
  end
endmodule : nvss_timer

/* verif/nvss_seq_asserts.sv */
`timescale 1ns/1ps
`include "nvss_map.svh"
module nvss_seq_asserts #(
  parameter int ACTIVE_CYC = 200,
  parameter int SS_CYC = 4000
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire nvss_pkg::nvss_cmd_t cmd,
  input wire logic cmd_valid,
  input wire logic sram_write,
  input wire logic hw_store_busy_line_in,
  input wire logic hw_store_busy_line_out,
  input wire logic hw_store_busy_line_oe,
  input wire logic access_inhibit,
  input wire logic busy,
  input wire logic nv_store_go,
  input wire logic nv_recall_go,
  input wire logic power_fail_store_en
);
  import nvss_pkg::*;
  localparam int WAKE = ACTIVE_CYC + 1;
  localparam int SS_MAX = SS_CYC;
  localparam int DRIVE = `NVSS_DRIVE_CYC;
  logic wr_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Pending write seen from the ports
  always_ff @(posedge mclk) begin
    if (!rst_b || nv_store_go || nv_recall_go) wr_q <= 1'b0;
    else if (sram_write && !access_inhibit) wr_q <= 1'b1;
  end
  sequence s_store_low;
    (!hw_store_busy_line_out && hw_store_busy_line_oe && access_inhibit) [*8];
  endsequence
  chk_skip_no_drive: assert property ($fell(hw_store_busy_line_in) && !busy && !wr_q
    |=> (!hw_store_busy_line_oe && !busy) [*8]) else $error("skipped request drove line");
  chk_grace_open: assert property (cmd_valid && !busy && cmd == NVSS_CMD_STORE
    |=> !access_inhibit [*4]) else $error("access closed during grace");
  chk_cycle_inhibit: assert property (nv_store_go || nv_recall_go
    |=> access_inhibit [*8]) else $error("access open during cycle");
  chk_line_low: assert property (!hw_store_busy_line_in
    |=> access_inhibit) else $error("access open while line low");
  chk_store_lock: assert property ($rose(nv_store_go)
    |=> s_store_low) else $error("store phase broken");
  chk_drive_short: assert property ($rose(hw_store_busy_line_out)
    |-> hw_store_busy_line_oe ##[1:DRIVE] !hw_store_busy_line_oe) else $error("drive high too long");
  chk_wake_soon: assert property ($fell(hw_store_busy_line_oe) && busy
    |-> ##[1:WAKE] !access_inhibit) else $error("wake too slow");
  chk_pfs_off: assert property (cmd_valid && !busy && cmd == NVSS_CMD_PFS_DIS
    |-> ##[1:SS_MAX] !power_fail_store_en) else $error("disable not applied");
endmodule : nvss_seq_asserts

/* verif/nvss_host.sv */
`timescale 1ns/1ps
module nvss_host (
  input wire logic pull_req,
  input wire logic line_out,
  input wire logic line_oe,
  output logic line
);
  // Open-drain host pull; weak pull-up when nobody drives
  assign line = (line_oe ? line_out : 1'b1) & !pull_req;
endmodule : nvss_host

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import nvss_pkg::*;
  logic mclk = 0, rst_b = 0, cmd_valid = 0, sram_write = 0, power_fail = 0, pull = 0;
  nvss_cmd_t cmd = NVSS_CMD_NONE;
  logic line, out, oe, inh, busy, sgo, rgo, pfs;
  logic [1:0] q[$];
  int num_errors = 0, n_compared = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  nvss_seq #(.STORE_CYC(100), .RECALL_CYC(50), .SS_CYC(20), .ACTIVE_CYC(10)) dut (
    .mclk(mclk), .rst_b(rst_b), .cmd(cmd), .cmd_valid(cmd_valid), .sram_write(sram_write),
    .power_fail(power_fail), .hw_store_busy_line_in(line), .hw_store_busy_line_out(out),
    .hw_store_busy_line_oe(oe), .access_inhibit(inh), .busy(busy), .nv_store_go(sgo),
    .nv_recall_go(rgo), .power_fail_store_en(pfs));
  nvss_host host (.pull_req(pull), .line_out(out), .line_oe(oe), .line(line));
  task chk(input logic [2:0] seen, input logic [2:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task report_and_stop;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task settle;
    int n;
    n = 0;
    tick(2);
    while (busy !== 1'b0 && n < 1000) begin
      tick(1);
      n++;
    end
    chk(busy, 3'h0, "settle");
    tick(2);
  endtask : settle
  task send(input nvss_cmd_t c, input logic e);
    cmd <= c;
    cmd_valid <= 1;
    if (e && c == NVSS_CMD_STORE) q.push_back(2'b10);
    if (e && c == NVSS_CMD_RECALL) q.push_back(2'b01);
    tick(1);
    cmd_valid <= 0;
    tick(1);
  endtask : send
  task wr;
    sram_write <= 1;
    tick(1);
    sram_write <= 0;
    tick(1);
  endtask : wr
  task hreq(input logic e);
    if (e) q.push_back(2'b10);
    pull <= 1;
    tick(2);
    @(negedge mclk);
    chk({oe, inh}, 2'b01, "line_req");
    @(posedge mclk);
    pull <= 0;
    // Random traffic while the store runs must all be ignored
    repeat (30) begin
      if (e) begin
        cmd <= nvss_cmd_t'($urandom_range(1, 4));
        cmd_valid <= 1'($urandom);
        sram_write <= 1'($urandom);
        power_fail <= 1'($urandom);
      end
      tick(1);
    end
    cmd_valid <= 0;
    sram_write <= 0;
    power_fail <= 0;
    @(negedge mclk);
    if (e) chk({out, oe, inh}, 3'b011, "store_low");
    @(posedge mclk);
    if (e) wr;
    settle;
  endtask : hreq
  always @(negedge mclk) begin
    cyc++;
    if (sgo | rgo) chk({sgo, rgo}, q.size() ? q.pop_front() : 2'b00, "go");
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop;
    end
  end
  initial begin
    void'($urandom(12189));
    tick(4);
    rst_b <= 1;
    tick(1);
    @(negedge mclk);
    chk({out, oe}, 2'b10, "line_rst");
    @(posedge mclk);
    hreq(0);
    repeat ($urandom_range(1, 4)) wr;
    hreq(1);
    hreq(0);
    for (int i = 1; i < 5; i++) begin
      send(nvss_cmd_t'(i), 1);
      if (i < 3) send(NVSS_CMD_RECALL, 0);
      tick(30);
      settle;
      if (i > 2) chk(pfs, i == 3, "pfs");
      wr;
      power_fail <= 1;
      if (i < 4) q.push_back(2'b10);
      tick(3);
      power_fail <= 0;
      settle;
    end
    chk(q.size() != 0, 3'h0, "pending");
    report_and_stop;
  end
endmodule : testbench
bind nvss_seq nvss_seq_asserts #(.ACTIVE_CYC(ACTIVE_CYC), .SS_CYC(SS_CYC)) u_chk (
  .mclk(mclk),
  .rst_b(rst_b),
  .cmd(cmd),
  .cmd_valid(cmd_valid),
  .sram_write(sram_write),
  .hw_store_busy_line_in(hw_store_busy_line_in),
  .hw_store_busy_line_out(hw_store_busy_line_out),
  .hw_store_busy_line_oe(hw_store_busy_line_oe),
  .access_inhibit(access_inhibit),
  .busy(busy),
  .nv_store_go(nv_store_go),
  .nv_recall_go(nv_recall_go),
  .power_fail_store_en(power_fail_store_en)
);
